// file: slmd_regs.svh
`ifndef SLMD_REGS_SVH
`define SLMD_REGS_SVH

// Port count driven by the strap group
`define SLMD_PORT_COUNT      6
// Width of the decoded six-level mode strap code
`define SLMD_LEVEL_WIDTH     3
// Decoded resistor level codes, in mode order one to six
`define SLMD_LEVEL_HI_PD     3'h0
`define SLMD_LEVEL_HI_PU     3'h1
`define SLMD_LEVEL_MID_PD    3'h2
`define SLMD_LEVEL_MID_PU    3'h3
`define SLMD_LEVEL_LO_PD     3'h4
`define SLMD_LEVEL_LO_PU     3'h5
// Reset values of the latched strap state
`define SLMD_RST_LEVEL       3'h0
`define SLMD_RST_DIS         6'h00

`endif

// file: slmd_pkg.sv
package slmd_pkg;

  // Mode settings one to six, plus a neutral value before the first capture
  typedef enum logic [2:0] {
    SLMD_MODE_NONE,
    SLMD_MODE_ONE,
    SLMD_MODE_TWO,
    SLMD_MODE_THREE,
    SLMD_MODE_FOUR,
    SLMD_MODE_FIVE,
    SLMD_MODE_SIX
  } slmd_mode_type;

  // Raw strap inputs as seen at the pins
  typedef struct packed {
    logic [2:0] modeLevel;
    logic [5:0] dplusDis;
    logic [5:0] dminusDis;
  } slmd_strap_type;

  // Decoded configuration handed to the rest of the hub
  typedef struct packed {
    logic       twoWireMaster;
    logic       twoWireTarget;
    logic       rateFlagEnable;
    logic       chargeFlagEnable;
    logic [5:0] usb2PortDisable;
    logic [5:0] usb3PortDisable;
  } slmd_config_type;

endpackage

// file: slmd_flag_pin.sv
`timescale 1ns/10ps
`include "slmd_regs.svh"

// One programmable pin: indicator drive when taken over, normal function otherwise
module slmd_flag_pin
  import slmd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic rateMode,
  input  wire logic chargeMode,
  input  wire logic portAttached,
  input  wire logic portSuperSpeed,
  input  wire logic chargeEnabled,
  input  wire logic chargeHandshakeDone,
  input  wire logic normalOut,
  input  wire logic normalOutEnable_n,
  output logic      pinOut,
  output logic      pinOutEnable_n
);

  typedef struct packed {
    logic pinOut;
    logic pinOutEnable_n;
  } slmd_pin_state_type;

  slmd_pin_state_type state;
  slmd_pin_state_type next_state;

  // Pick pin level and enable from the mode the straps chose
  always_comb begin
    next_state = state;
    if (rateMode) begin
      next_state.pinOutEnable_n = ~portAttached;
      next_state.pinOut         = portSuperSpeed;
    end else if (chargeMode) begin
      next_state.pinOutEnable_n = ~chargeEnabled;
      next_state.pinOut         = ~chargeHandshakeDone;
    end else begin
      next_state.pinOutEnable_n = normalOutEnable_n;
      next_state.pinOut         = normalOut;
    end
  end

  // Pin floats during reset so nothing is driven before straps settle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '{pinOut: 1'b0, pinOutEnable_n: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign pinOut         = state.pinOut;
  assign pinOutEnable_n = state.pinOutEnable_n;

endmodule

// file: slmd_strap_latch.sv
`timescale 1ns/10ps
`include "slmd_regs.svh"

// Summary of operation
// - Capture all straps at reset release, hold
// - Six resistor levels map to settings one-six
// - Setting one: two-wire master, rate flags on
// - Setting two: two-wire target, rate flags on
// - Settings one, two take over six pins
// - Rate flag: float idle, 0 USB2, 1 Gen1
// - Setting five: pins become charge flags
// - Charge flag: float off, 0 done, 1 pending
// - D+ strap: 0 enabled, 1 disabled
// - D- strap: 0 enabled, 1 disabled
// - Port disabled only if both straps high
// - USB2 disable also disables Gen1 path
module slmd_strap_latch
  import slmd_pkg::*;
#(
  parameter int PORTS = `SLMD_PORT_COUNT
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire slmd_strap_type   strapIn,
  input  wire logic [PORTS-1:0] portAttached,
  input  wire logic [PORTS-1:0] portSuperSpeed,
  input  wire logic [PORTS-1:0] chargeEnabled,
  input  wire logic [PORTS-1:0] chargeHandshakeDone,
  input  wire logic [PORTS-1:0] normalOut,
  input  wire logic [PORTS-1:0] normalOutEnable_n,
  output slmd_config_type       config_o,
  output slmd_mode_type         latchedMode,
  output logic                  strapsValid,
  output logic [PORTS-1:0]      pinOut,
  output logic [PORTS-1:0]      pinOutEnable_n
);

  typedef struct packed {
    slmd_strap_type  syncA;
    slmd_strap_type  syncB;
    logic            armed;
    logic            captured;
    slmd_mode_type   mode;
    logic [5:0]      dplus;
    logic [5:0]      dminus;
    slmd_config_type cfg;
  } slmd_latch_state_type;

  slmd_latch_state_type state;
  slmd_latch_state_type next_state;
  slmd_mode_type        decodedMode;
  logic [5:0]           bothHigh;

  // Six-level strap to setting number
  always_comb begin
    case (state.syncB.modeLevel)
      `SLMD_LEVEL_HI_PD:  decodedMode = SLMD_MODE_ONE;
      `SLMD_LEVEL_HI_PU:  decodedMode = SLMD_MODE_TWO;
      `SLMD_LEVEL_MID_PD: decodedMode = SLMD_MODE_THREE;
      `SLMD_LEVEL_MID_PU: decodedMode = SLMD_MODE_FOUR;
      `SLMD_LEVEL_LO_PD:  decodedMode = SLMD_MODE_FIVE;
      `SLMD_LEVEL_LO_PU:  decodedMode = SLMD_MODE_SIX;
      default:            decodedMode = SLMD_MODE_THREE;
    endcase
  end

  // A lone high strap has no effect; the port is disabled only when both are high
  assign bothHigh = state.dplus & state.dminus;

  // Capture once, two cycles after release, when the synchronised straps are valid
  always_comb begin
    next_state       = state;
    next_state.syncA = strapIn;
    next_state.syncB = state.syncA;
    next_state.armed = 1'b1;
    if (state.armed && !state.captured) begin
      next_state.captured = 1'b1;
      next_state.mode     = decodedMode;
      next_state.dplus    = state.syncB.dplusDis;
      next_state.dminus   = state.syncB.dminusDis;
    end
    next_state.cfg.twoWireMaster    = state.mode == SLMD_MODE_ONE;
    next_state.cfg.twoWireTarget    = state.mode == SLMD_MODE_TWO;
    next_state.cfg.rateFlagEnable   = state.mode == SLMD_MODE_ONE ||
                                      state.mode == SLMD_MODE_TWO;
    next_state.cfg.chargeFlagEnable = state.mode == SLMD_MODE_FIVE;
    next_state.cfg.usb2PortDisable  = bothHigh;
    next_state.cfg.usb3PortDisable  = bothHigh;
  end

  // Synchronous reset clears capture; the synchroniser keeps running through reset
  // so that the straps are already valid in syncB when capture happens after release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state.syncA    <= strapIn;
      state.syncB    <= state.syncA;
      state.armed    <= 1'b0;
      state.captured <= 1'b0;
      state.mode     <= SLMD_MODE_NONE;
      state.dplus    <= `SLMD_RST_DIS;
      state.dminus   <= `SLMD_RST_DIS;
      state.cfg      <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign config_o    = state.cfg;
  assign latchedMode = state.mode;
  assign strapsValid = state.captured;

  // One pin driver per downstream port
  for (genvar p = 0; p < PORTS; p++) begin : g_pin
    slmd_flag_pin u_pin (
      .clk                 (clk),
      .rst_n               (rst_n),
      .rateMode            (state.cfg.rateFlagEnable),
      .chargeMode          (state.cfg.chargeFlagEnable),
      .portAttached        (portAttached[p]),
      .portSuperSpeed      (portSuperSpeed[p]),
      .chargeEnabled       (chargeEnabled[p]),
      .chargeHandshakeDone (chargeHandshakeDone[p]),
      .normalOut           (normalOut[p]),
      .normalOutEnable_n   (normalOutEnable_n[p]),
      .pinOut              (pinOut[p]),
      .pinOutEnable_n      (pinOutEnable_n[p])
    );
  end

endmodule

// file: slmd_strap_latch_sva.sv
`timescale 1ns/10ps
// Port-level checks of strap capture, mode decode and pin takeover
module slmd_strap_latch_sva
  import slmd_pkg::*;
#(
  parameter int PORTS = 6
)(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire slmd_strap_type   strapIn,
  input wire logic [PORTS-1:0] portAttached,
  input wire logic [PORTS-1:0] portSuperSpeed,
  input wire logic [PORTS-1:0] chargeEnabled,
  input wire logic [PORTS-1:0] chargeHandshakeDone,
  input wire logic [PORTS-1:0] normalOut,
  input wire logic [PORTS-1:0] normalOutEnable_n,
  input wire slmd_config_type  config_o,
  input wire slmd_mode_type    latchedMode,
  input wire logic             strapsValid,
  input wire logic [PORTS-1:0] pinOut,
  input wire logic [PORTS-1:0] pinOutEnable_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Capture moment, then the settled phase once the decode has landed
  sequence s_capture;
    $rose(strapsValid);
  endsequence
  sequence s_settled;
    strapsValid && $past(strapsValid, 2);
  endsequence
  a_mode_decode: assert property (s_capture |-> latchedMode == ((strapIn.modeLevel > 3'h5) ?
    SLMD_MODE_THREE : slmd_mode_type'(strapIn.modeLevel + 3'h1))) else $error("mode decode");
  a_mode_held: assert property (strapsValid && $past(strapsValid) |-> $stable(latchedMode))
    else $error("mode changed after capture");
  a_config_held: assert property (s_settled |-> $stable(config_o)) else $error("config moved");
  a_master_target: assert property (s_capture |=> config_o.twoWireMaster ==
    (latchedMode == SLMD_MODE_ONE) && config_o.twoWireTarget == (latchedMode == SLMD_MODE_TWO))
    else $error("two-wire role wrong");
  a_flag_enables: assert property (s_capture |=> config_o.rateFlagEnable == (latchedMode ==
    SLMD_MODE_ONE || latchedMode == SLMD_MODE_TWO) && config_o.chargeFlagEnable ==
    (latchedMode == SLMD_MODE_FIVE)) else $error("indicator enable wrong");
  a_port_disable: assert property (s_capture |=>
    config_o.usb2PortDisable == (strapIn.dplusDis & strapIn.dminusDis)) else $error("disable");
  a_gen1_follow: assert property (config_o.usb3PortDisable == config_o.usb2PortDisable)
    else $error("Gen1 path disable differs");
  a_rate_pin: assert property ($past(config_o.rateFlagEnable) |-> pinOutEnable_n ==
    ~$past(portAttached) && pinOut == $past(portSuperSpeed)) else $error("rate pin wrong");
  a_charge_pin: assert property ($past(config_o.chargeFlagEnable) |-> pinOutEnable_n ==
    ~$past(chargeEnabled) && pinOut == ~$past(chargeHandshakeDone)) else $error("charge pin");
  a_normal_pin: assert property ($past(rst_n) && !$past(config_o.rateFlagEnable) &&
    !$past(config_o.chargeFlagEnable) |-> pinOutEnable_n == $past(normalOutEnable_n) &&
    pinOut == $past(normalOut)) else $error("pin not in normal function");
endmodule
bind slmd_strap_latch slmd_strap_latch_sva #(.PORTS(PORTS)) u_sva (.clk, .rst_n, .strapIn,
  .portAttached, .portSuperSpeed, .chargeEnabled, .chargeHandshakeDone, .normalOut,
  .normalOutEnable_n, .config_o, .latchedMode, .strapsValid, .pinOut, .pinOutEnable_n);

// file: slmd_board.sv
`timescale 1ns/10ps
// Board strap resistors seen as already-decoded static pin levels
module slmd_board
  import slmd_pkg::*;
(
  input  wire logic [2:0] levelSel,
  input  wire logic [5:0] dplusSel,
  input  wire logic [5:0] dminusSel,
  output slmd_strap_type  strapIn
);
  // Choices move while reset is held and again after capture, so they are settled before capture
  assign strapIn = '{modeLevel: levelSel, dplusDis: dplusSel, dminusDis: dminusSel};
endmodule

// file: slmd_strap_latch_tb.sv
`timescale 1ns/10ps
module slmd_strap_latch_tb
  import slmd_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, valid;
  logic [2:0] lvl = 3'h0, expMode;
  logic [5:0] dp = 6'h00, dm = 6'h00, att = 6'h2d, ss = 6'h26, ce = 6'h33, hd = 6'h15;
  logic [5:0] no = 6'h0f, noe = 6'h3c, pOut, pEn_n, expEn, expOut;
  logic [15:0] expCfg;
  slmd_strap_type strapIn;
  slmd_config_type cfg;
  slmd_mode_type mode;
  int fail_count = 0, samples_checked = 0;
  slmd_board board (.levelSel(lvl), .dplusSel(dp), .dminusSel(dm), .strapIn(strapIn));
  slmd_strap_latch DUT (.clk(clk), .rst_n(rst_n), .strapIn(strapIn), .portAttached(att),
    .portSuperSpeed(ss), .chargeEnabled(ce), .chargeHandshakeDone(hd), .normalOut(no),
    .normalOutEnable_n(noe), .config_o(cfg), .latchedMode(mode), .strapsValid(valid),
    .pinOut(pOut), .pinOutEnable_n(pEn_n));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Inputs move 1 ns after the rising edge, apart from the first settings at time 0
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Every level code, reserved ones too, with mixed single and paired disable ties
  initial begin
    for (int m = 0; m < 8; m++) begin
      rst_n = 1'b0;
      lvl = 3'(m);
      dp = 6'h35 ^ 6'(m);
      dm = 6'h1e;
      cycles(4);
      rst_n = 1'b1;
      cycles(5);
      expMode = (m > 5) ? 3'h3 : 3'(m + 1);
      expCfg = {m == 0, m == 1, m < 2, m == 4, dp & dm, dp & dm};
      cmp(16'(valid), 16'h0001);
      cmp(16'(mode), 16'(expMode));
      cmp(16'(cfg), expCfg);
      // Straps flipped after capture must leave everything as latched
      lvl = ~lvl;
      dp = ~dp;
      dm = ~dm;
      for (int k = 0; k < 2; k++) begin
        cycles(3);
        cmp(16'(mode), 16'(expMode));
        cmp(16'(cfg), expCfg);
        expEn = (m < 2) ? ~att : (m == 4) ? ~ce : noe;
        expOut = (m < 2) ? ss : (m == 4) ? ~hd : no;
        cmp({4'h0, pEn_n, pOut}, {4'h0, expEn, expOut});
        {att, ss, ce, hd, no, noe} = ~{att, ss, ce, hd, no, noe};
      end
    end
    finish_test();
  end
  // About 120 cycles expected; a generous margin before giving up
  initial begin
    #5000;
    fail_count++;
    finish_test();
  end
endmodule
